// >>> clock_controller.sv
/*
 * Core and peripheral clock controller. Crystal and PLL clocks arrive
 * as pins, are sampled on pclk and turned into tick strobes; every
 * generated clock leaves as a registered one-cycle enable or a divided
 * level. Registers sit on an APB slave with no wait states.
 * Assumes the crystal and PLL pins toggle at under a quarter of pclk.
 */
`timescale 1ns/1ps

module clock_controller
   import clock_ctrl_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   input  wire logic        crystal_input_pin,
   input  wire logic        pll_clock_pin,
   input  wire logic        pll_lock_pin,
   output wire logic        pll_enable,
   output wire logic        core_clock,
   output wire logic        peripheral_bus_clock,
   output wire logic        timer0_clock,
   output wire logic        timer1_clock,
   output wire logic        uart_clock,
   output wire logic        watchdog_clock,
   output wire logic        serial_periph_clock,
   output wire logic        usb_clock,
   output wire logic        card_protocol_clock,
   output wire logic        alt_card_clock,
   output wire logic        converter_clock
);
   typedef struct packed
   {
      logic [2:0]  xtal_sync;
      logic [2:0]  pll_sync;
      logic [1:0]  lock_sync;
      logic        clock_source_select;
      logic [3:0]  main_divider_reload;
      logic [5:0]  speed_cfg;
      logic [5:0]  card_clock_divider;
      logic [1:0]  alt_clock_div_sel;
      logic [3:0]  converter_clock_divider;
      power_mode_t power_mode;
      logic        pll_en;
      logic        act_source;
      logic        act_double;
      logic [31:0] rdata;
      logic [6:0]  ticks;
      logic [2:0]  levels;
      logic        usb;
   } ctrl_state_t;

   ctrl_state_t state;
   ctrl_state_t next_state;
   logic        xtal_tick;
   logic        pll_tick;
   logic        src_tick;
   logic        core_tick;
   logic        periph_div_tick;
   logic        setup;
   logic        wr_access;
   logic        run_ok;
   logic        idle_ok;

   tick_div_if #(.W(DIV_W)) div_link [NUM_DIV] ();

   // Known register decode, used only for the slave error on reads and writes
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         SOURCE_SEL_OFFSET, RELOAD_OFFSET, SPEED_CFG_OFFSET,
         CARD_DIV_OFFSET, ALT_DIV_OFFSET, CONV_DIV_OFFSET,
         POWER_MODE_OFFSET, PLL_CTRL_OFFSET: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // Per-peripheral choice: divided tick, or raw source in double speed when its X2 bit is clear
   function automatic logic periph_pick(input logic x2_bit,
                                        input logic dbl,
                                        input logic raw,
                                        input logic divd);
      periph_pick = (dbl && !x2_bit) ? raw : divd;
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < NUM_DIV; gi++)
      begin : g_div
         tick_divider #(.W(DIV_W)) u_div
         (
            .pclk    (pclk),
            .presetn (presetn),
            .port    (div_link[gi].div)
         );
      end
   endgenerate

   // Edges are taken from the second and third sync stages only
   assign xtal_tick = state.xtal_sync[1] & ~state.xtal_sync[2];
   assign pll_tick  = state.pll_sync[1] & ~state.pll_sync[2];
   assign src_tick  = state.act_source ? pll_tick : xtal_tick;
   assign core_tick = state.act_double ? xtal_tick
                                       : div_link[DIV_MAIN].rise;
   assign periph_div_tick = div_link[DIV_MAIN].rise;

   // Divider feeds
   assign div_link[DIV_MAIN].src_tick = src_tick;
   assign div_link[DIV_MAIN].half =
      MAIN_RELOAD_SPAN - {4'h0, state.main_divider_reload};
   assign div_link[DIV_CARD].src_tick = pll_tick;
   assign div_link[DIV_CARD].half =
      CARD_HALF_BASE + {2'h0, state.card_clock_divider};
   assign div_link[DIV_ALT].src_tick = periph_div_tick;
   assign div_link[DIV_ALT].half = (state.alt_clock_div_sel == 2'h0)
      ? 8'h01 : DIV_W'(1 << (state.alt_clock_div_sel - 2'h1));
   assign div_link[DIV_CONV].src_tick = xtal_tick;
   assign div_link[DIV_CONV].half =
      {4'h0, state.converter_clock_divider} + 8'h01;
   assign div_link[DIV_USB].src_tick = pll_tick;
   assign div_link[DIV_USB].half = 8'h01;

   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   assign run_ok    = (state.power_mode == PM_RUN);
   assign idle_ok   = (state.power_mode != PM_POWER_DOWN);

   // Sync, register writes, read capture and clock output registers
   always_comb
   begin
      next_state = state;
      next_state.xtal_sync = {state.xtal_sync[1:0], crystal_input_pin};
      next_state.pll_sync  = {state.pll_sync[1:0], pll_clock_pin};
      next_state.lock_sync = {state.lock_sync[0], pll_lock_pin};
      if (div_link[DIV_MAIN].rise || !state.act_double)
      begin
         next_state.act_source = state.clock_source_select;
         next_state.act_double = state.speed_cfg[DOUBLE_SPEED_POS];
      end
      if (wr_access)
      begin
         case (paddr)
            SOURCE_SEL_OFFSET:
               if (!(pwdata[0] && state.speed_cfg[DOUBLE_SPEED_POS]))
                  next_state.clock_source_select = pwdata[0];
            RELOAD_OFFSET:
               next_state.main_divider_reload = pwdata[3:0];
            SPEED_CFG_OFFSET:
               if (!(pwdata[DOUBLE_SPEED_POS] && state.clock_source_select))
                  next_state.speed_cfg = pwdata[5:0];
            CARD_DIV_OFFSET:
               next_state.card_clock_divider = pwdata[5:0];
            ALT_DIV_OFFSET:
               next_state.alt_clock_div_sel = pwdata[1:0];
            CONV_DIV_OFFSET:
               next_state.converter_clock_divider = pwdata[3:0];
            POWER_MODE_OFFSET:
               next_state.power_mode = (pwdata[1:0] == 2'h2)
                  ? state.power_mode : power_mode_t'(pwdata[1:0]);
            PLL_CTRL_OFFSET:
               next_state.pll_en = pwdata[PLL_EN_POS];
            default: ;
         endcase
      end
      if (setup)
      begin
         case (paddr)
            SOURCE_SEL_OFFSET:
               next_state.rdata = {31'h0, state.clock_source_select};
            RELOAD_OFFSET:
               next_state.rdata = {28'h0, state.main_divider_reload};
            SPEED_CFG_OFFSET:
               next_state.rdata = {26'h0, state.speed_cfg};
            CARD_DIV_OFFSET:
               next_state.rdata = {26'h0, state.card_clock_divider};
            ALT_DIV_OFFSET:
               next_state.rdata = {30'h0, state.alt_clock_div_sel};
            CONV_DIV_OFFSET:
               next_state.rdata = {28'h0, state.converter_clock_divider};
            POWER_MODE_OFFSET:
               next_state.rdata = {30'h0, state.power_mode};
            PLL_CTRL_OFFSET:
               next_state.rdata = {30'h0, state.lock_sync[1], state.pll_en};
            default:
               next_state.rdata = 32'h0;
         endcase
      end
      // Gating by power mode; idle stops the core only
      next_state.ticks[0] = core_tick & run_ok;
      next_state.ticks[1] = core_tick & idle_ok;
      next_state.ticks[2] = idle_ok & periph_pick(
         state.speed_cfg[T0_X2_POS], state.act_double, src_tick,
         periph_div_tick);
      next_state.ticks[3] = idle_ok & periph_pick(
         state.speed_cfg[T1_X2_POS], state.act_double, src_tick,
         periph_div_tick);
      next_state.ticks[4] = idle_ok & periph_pick(
         state.speed_cfg[UART_X2_POS], state.act_double, src_tick,
         periph_div_tick);
      next_state.ticks[5] = idle_ok & periph_pick(
         state.speed_cfg[WD_X2_POS], state.act_double, src_tick,
         periph_div_tick);
      next_state.ticks[6] = idle_ok & periph_pick(
         state.speed_cfg[SPI_X2_POS], state.act_double, src_tick,
         periph_div_tick);
      next_state.levels[0] = div_link[DIV_CARD].level & idle_ok;
      next_state.levels[1] = (state.alt_clock_div_sel == 2'h0)
         ? (periph_div_tick & idle_ok)
         : (div_link[DIV_ALT].level & idle_ok);
      next_state.levels[2] = div_link[DIV_CONV].level & idle_ok;
      // USB tick is the PLL halved, registered so no runt
      next_state.usb = div_link[DIV_USB].rise & idle_ok;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= '0;
         state.clock_source_select     <= SOURCE_SEL_RESET;
         state.main_divider_reload     <= RELOAD_RESET;
         state.speed_cfg               <= SPEED_CFG_RESET;
         state.card_clock_divider      <= CARD_DIV_RESET;
         state.alt_clock_div_sel       <= ALT_DIV_RESET;
         state.converter_clock_divider <= CONV_DIV_RESET;
         state.power_mode              <= PM_RUN;
      end
      else
         state <= next_state;
   end

   assign prdata    = state.rdata;
   assign pready    = 1'b1;   // Zero wait states
   assign pslverr   = psel & penable & ~mapped(paddr);
   assign pll_enable           = state.pll_en;
   assign core_clock           = state.ticks[0];
   assign peripheral_bus_clock = state.ticks[1];
   assign timer0_clock         = state.ticks[2];
   assign timer1_clock         = state.ticks[3];
   assign uart_clock           = state.ticks[4];
   assign watchdog_clock       = state.ticks[5];
   assign serial_periph_clock  = state.ticks[6];
   assign usb_clock            = state.usb;
   assign card_protocol_clock  = state.levels[0];
   assign alt_card_clock       = state.levels[1];
   assign converter_clock      = state.levels[2];
endmodule

// >>> clock_ctrl_pkg.sv
/*
 * Constants for the core and peripheral clock controller: register
 * offsets on the APB window, field positions, reset values and modes.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package clock_ctrl_pkg;

   // Register byte offsets
   localparam logic [7:0] SOURCE_SEL_OFFSET  = 8'h00;
   localparam logic [7:0] RELOAD_OFFSET      = 8'h04;
   localparam logic [7:0] SPEED_CFG_OFFSET   = 8'h08;
   localparam logic [7:0] CARD_DIV_OFFSET    = 8'h0C;
   localparam logic [7:0] ALT_DIV_OFFSET     = 8'h10;
   localparam logic [7:0] CONV_DIV_OFFSET    = 8'h14;
   localparam logic [7:0] POWER_MODE_OFFSET  = 8'h18;
   localparam logic [7:0] PLL_CTRL_OFFSET    = 8'h1C;

   // Speed configuration and PLL control field positions
   localparam int DOUBLE_SPEED_POS = 0;
   localparam int T0_X2_POS        = 1;
   localparam int T1_X2_POS        = 2;
   localparam int UART_X2_POS      = 3;
   localparam int WD_X2_POS        = 4;
   localparam int SPI_X2_POS       = 5;
   localparam int PLL_EN_POS       = 0;
   localparam int PLL_LOCK_POS     = 1;

   // Reset values
   localparam logic       SOURCE_SEL_RESET = 1'b0;
   localparam logic [3:0] RELOAD_RESET     = 4'hF;
   localparam logic [5:0] SPEED_CFG_RESET  = 6'h00;
   localparam logic [5:0] CARD_DIV_RESET   = 6'h00;
   localparam logic [1:0] ALT_DIV_RESET    = 2'h0;
   localparam logic [3:0] CONV_DIV_RESET   = 4'h0;

   // Divider arithmetic
   localparam logic [7:0] MAIN_RELOAD_SPAN = 8'h10;
   localparam logic [7:0] CARD_HALF_BASE   = 8'h04;
   localparam int         DIV_W            = 8;
   localparam int         NUM_DIV          = 5;
   localparam int         DIV_MAIN         = 0;
   localparam int         DIV_CARD         = 1;
   localparam int         DIV_ALT          = 2;
   localparam int         DIV_CONV         = 3;
   localparam int         DIV_USB          = 4;

   // Power reduction modes
   typedef enum logic [1:0]
   {
      PM_RUN        = 2'h0,
      PM_IDLE       = 2'h1,
      PM_POWER_DOWN = 2'h3
   } power_mode_t;

endpackage

// >>> clock_ctrl_properties.sv
/*
 * Checker for the clock controller ports: APB answer, clock shapes and
 * power gating. Assumes pin clocks stay under a quarter of pclk.
 */
`timescale 1ns/1ps
module clock_ctrl_checker
   import clock_ctrl_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        pll_enable,
   input wire logic        core_clock,
   input wire logic        peripheral_bus_clock,
   input wire logic        usb_clock,
   input wire logic        card_protocol_clock,
   input wire logic        converter_clock
);
   logic [1:0] pm;
   logic [4:0] stop_cnt;
   logic       acc;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Access phase strobe
   assign acc = psel && penable;

   // Power mode mirror; code 2 is refused, so it never lands here
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pm       <= 2'h0;
         stop_cnt <= 5'h00;
      end
      else
      begin
         if (acc && pwrite && paddr == POWER_MODE_OFFSET
             && pwdata[1:0] != 2'h2)
            pm <= pwdata[1:0];
         if (acc && pwrite && paddr == POWER_MODE_OFFSET)
            stop_cnt <= 5'h00;
         else if (pm != 2'h0 && stop_cnt != 5'h14)
            stop_cnt <= stop_cnt + 5'h01;
      end

   a_ready_high: assert property
      (pready)
      else $error("Slave inserted a wait state");
   a_unmapped_err: assert property
      (acc && paddr > PLL_CTRL_OFFSET |-> pslverr)
      else $error("Unmapped access gave no slave error");
   a_mapped_ok: assert property
      (acc && paddr[1:0] == 2'h0 && paddr <= PLL_CTRL_OFFSET |-> !pslverr)
      else $error("Mapped access gave a slave error");
   a_pll_enable: assert property
      (acc && pwrite && paddr == PLL_CTRL_OFFSET
       |=> pll_enable == $past(pwdata[PLL_EN_POS]))
      else $error("PLL enable does not follow its write");
   a_core_pulse: assert property
      (core_clock |=> !core_clock)
      else $error("Core clock enable wider than one cycle");
   a_usb_pulse: assert property
      ($rose(usb_clock) |=> $fell(usb_clock))
      else $error("USB clock enable wider than one cycle");
   a_card_hold: assert property
      ($rose(card_protocol_clock) |-> card_protocol_clock[*6])
      else $error("Card clock high phase too short");
   a_conv_hold: assert property
      ($fell(converter_clock) |-> !converter_clock[*2])
      else $error("Converter clock low phase too short");
   a_idle_core: assert property
      (stop_cnt == 5'h14 |-> !core_clock)
      else $error("Core clock runs in a reduced power mode");
   a_pdown_all: assert property
      (stop_cnt == 5'h14 && pm == PM_POWER_DOWN
       |-> !peripheral_bus_clock && !usb_clock && $stable(converter_clock))
      else $error("Clock still running in power down");

   c_slave_err: cover property (acc && pslverr);
   c_card_rise: cover property ($rose(card_protocol_clock));
   c_power_down: cover property (stop_cnt == 5'h14 && pm == PM_POWER_DOWN);
endmodule

bind clock_controller clock_ctrl_checker u_clock_ctrl_checker
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .pll_enable(pll_enable), .core_clock(core_clock),
   .peripheral_bus_clock(peripheral_bus_clock), .usb_clock(usb_clock),
   .card_protocol_clock(card_protocol_clock),
   .converter_clock(converter_clock)
);

// >>> clock_source_model.sv
/*
 * Far-side clock sources: crystal pin, PLL output and its lock flag.
 * Assumes both clocks stay under a quarter of the 100 MHz pclk.
 */
`timescale 1ns/1ps
module clock_source_model
#(
   parameter int XTAL_HALF_NS = 27,
   parameter int PLL_HALF_NS  = 37,
   parameter int LOCK_NS      = 1500
)
(
   input  wire logic pll_enable,
   output logic      crystal_input_pin,
   output logic      pll_clock_pin,
   output logic      pll_lock_pin
);
   // Crystal runs free once powered
   initial
   begin
      crystal_input_pin = 1'b0;
      forever #(XTAL_HALF_NS) crystal_input_pin = ~crystal_input_pin;
   end

   // PLL output stands low while disabled
   initial
   begin
      pll_clock_pin = 1'b0;
      forever
         #(PLL_HALF_NS) pll_clock_pin =
            (pll_enable === 1'b1) & ~pll_clock_pin;
   end

   // Lock comes late after enable, so early use is caught
   initial
   begin
      pll_lock_pin = 1'b0;
      forever
      begin
         @(pll_enable);
         pll_lock_pin = 1'b0;
         if (pll_enable === 1'b1)
            #(LOCK_NS) pll_lock_pin = pll_enable;
      end
   end
endmodule

// >>> tb.sv
/*
 * Self-checking bench for the clock controller: registers over APB,
 * divided clock rates, source choice and power gating.
 * Assumes the source model keeps pin clocks under a quarter of pclk.
 */
`timescale 1ns/1ps
module tb
   import clock_ctrl_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        xtal, pll_clk, lock, pll_en;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, d;
   logic [31:0] mir [7];
   logic [31:0] mask [7] = '{32'h1, 32'hF, 32'h3F, 32'h3F,
                             32'h3, 32'hF, 32'h3};
   logic [10:0] outs, outs_q;
   int          cnt [11];
   int          rl [3] = '{10, 0, 15};
   int          cnt_x, cnt_p, error_cnt, checked, seed, i, j;

   clock_controller u_clock_controller
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .crystal_input_pin(xtal),
      .pll_clock_pin(pll_clk), .pll_lock_pin(lock), .pll_enable(pll_en),
      .core_clock(outs[10]), .peripheral_bus_clock(outs[9]),
      .timer0_clock(outs[8]), .timer1_clock(outs[7]), .uart_clock(outs[6]),
      .watchdog_clock(outs[5]), .serial_periph_clock(outs[4]),
      .usb_clock(outs[3]), .card_protocol_clock(outs[2]),
      .alt_card_clock(outs[1]), .converter_clock(outs[0])
   );

   clock_source_model u_clock_source_model
   (
      .pll_enable(pll_en), .crystal_input_pin(xtal),
      .pll_clock_pin(pll_clk), .pll_lock_pin(lock)
   );

   // 100 MHz bus clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Rising edges of source pins and of every generated clock
   always @(posedge xtal) cnt_x++;
   always @(posedge pll_clk) cnt_p++;
   always @(posedge pclk)
   begin
      for (int b = 0; b < 11; b++)
         if (outs[b] === 1'b1 && outs_q[b] !== 1'b1)
            cnt[b]++;
      outs_q <= outs;
   end

   // Tolerance absorbs divider phase at the window edges
   task automatic check(input logic [31:0] seen, exp, tol);
      checked++;
      if (((seen - exp <= tol) || (exp - seen <= tol)) !== 1'b1)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits for pready, only the watchdog bounds it
   task automatic apb(input logic [7:0]  a,
                      input logic        w,
                      input logic [31:0] v);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      check(rd, exp, 32'h0);
   endtask

   // Settle after a change, then count over a fixed window
   task automatic measure();
      repeat (600) @(posedge pclk);
      @(negedge pclk);
      cnt_x = 0;
      cnt_p = 0;
      foreach (cnt[b]) cnt[b] = 0;
      repeat (3000) @(posedge pclk);
      @(negedge pclk);
   endtask

   function automatic logic [31:0] rate(int src, int div);
      return 32'(src / div);
   endfunction

   // Register model with the refused combinations left out
   function automatic logic [31:0] nextval(int r, logic [31:0] v);
      v = v & mask[r];
      if ((r == 0 && v[0] && mir[2][0]) || (r == 2 && v[0] && mir[0][0])
          || (r == 6 && v == 32'h2))
         return mir[r];
      return v;
   endfunction

   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, well past the expected run
   initial
   begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      final_report();
   end

   initial
   begin
      seed = 98;
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i++)
      begin
         mir[i] = (i == 1) ? 32'hF : 32'h0;
         rdchk(8'(4 * i), mir[i]);
      end
      rdchk(PLL_CTRL_OFFSET, 32'h0);
      apb(8'h20, 1'b1, 32'h5);
      check(err, 32'h1, 32'h0);
      apb(8'hFC, 1'b0, 32'h0);
      check(rd, 32'h0, 32'h0);
      done("reset and decode");
      apb(SPEED_CFG_OFFSET, 1'b1, 32'h1);
      mir[2] = 32'h1;
      apb(SOURCE_SEL_OFFSET, 1'b1, 32'h1);
      rdchk(SOURCE_SEL_OFFSET, 32'h0);
      for (j = 0; j < 24; j++)
      begin
         i = {$random(seed)} % 7;
         d = $random(seed);
         apb(8'(4 * i), 1'b1, d);
         mir[i] = nextval(i, d);
         rdchk(8'(4 * i), mir[i]);
      end
      for (i = 6; i >= 0; i--)
         apb(8'(4 * i), 1'b1, (i == 1) ? 32'hF : 32'h0);
      done("register access");
      foreach (rl[k])
      begin
         apb(RELOAD_OFFSET, 1'b1, 32'(rl[k]));
         measure();
         check(cnt[10], rate(cnt_x, 2 * (16 - rl[k])), 32'h2);
         for (i = 4; i < 10; i++)
            check(cnt[i], rate(cnt_x, 2 * (16 - rl[k])), 32'h2);
      end
      apb(SPEED_CFG_OFFSET, 1'b1, 32'h1);
      measure();
      check(cnt[10], cnt_x, 32'h2);
      check(cnt[8], cnt_x, 32'h2);
      apb(SPEED_CFG_OFFSET, 1'b1, 32'h3F);
      measure();
      check(cnt[8], rate(cnt_x, 2), 32'h2);
      apb(SPEED_CFG_OFFSET, 1'b1, 32'h0);
      done("crystal rates");
      apb(PLL_CTRL_OFFSET, 1'b1, 32'h1);
      rd = 32'h0;
      for (i = 0; i < 100 && rd[PLL_LOCK_POS] !== 1'b1; i++)
         apb(PLL_CTRL_OFFSET, 1'b0, 32'h0);
      check(rd, 32'h3, 32'h0);
      apb(SOURCE_SEL_OFFSET, 1'b1, 32'h1);
      apb(SPEED_CFG_OFFSET, 1'b1, 32'h1);
      rdchk(SPEED_CFG_OFFSET, 32'h0);
      // Core at 5x the card clock: inside the working band, and under
      // 6x, so no card register spacing is owed
      apb(CARD_DIV_OFFSET, 1'b1, 32'h1);
      apb(ALT_DIV_OFFSET, 1'b1, 32'h3);
      apb(CONV_DIV_OFFSET, 1'b1, 32'h3);
      measure();
      check(cnt[10], rate(cnt_p, 2), 32'h2);
      check(cnt[3], rate(cnt_p, 2), 32'h2);
      check(cnt[2], rate(cnt_p, 10), 32'h2);
      check(cnt[1], rate(cnt_p, 16), 32'h2);
      check(cnt[0], rate(cnt_x, 8), 32'h2);
      done("PLL clocks");
      apb(POWER_MODE_OFFSET, 1'b1, 32'(PM_IDLE));
      measure();
      check(cnt[10], 32'h0, 32'h0);
      check(cnt[9], rate(cnt_p, 2), 32'h2);
      // Cut the card clock in a low phase, never inside a high one
      @(negedge outs[2]);
      apb(POWER_MODE_OFFSET, 1'b1, 32'(PM_POWER_DOWN));
      apb(POWER_MODE_OFFSET, 1'b1, 32'h2);
      rdchk(POWER_MODE_OFFSET, 32'(PM_POWER_DOWN));
      measure();
      foreach (cnt[k])
         check(cnt[k], 32'h0, 32'h0);
      done("power modes");
      final_report();
   end
endmodule

// >>> tick_div_if.sv
/*
 * Carrier between the controller and one tick divider: source tick,
 * half-period length, divided level and its rising pulse.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
interface tick_div_if #(parameter int W = 8);
   logic         src_tick;
   logic [W-1:0] half;
   logic         level;
   logic         rise;

   modport ctrl
   (
      output src_tick,
      output half,
      input  level,
      input  rise
   );
   modport div
   (
      input  src_tick,
      input  half,
      output level,
      output rise
   );
endinterface

// >>> tick_divider.sv
/*
 * Divides a stream of source ticks into a 50 percent duty level and a
 * one-cycle pulse at each rising edge of that level.
 * Assumes half is at least one; zero is served as one.
 */
`timescale 1ns/1ps
module tick_divider
   import clock_ctrl_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic   pclk,
   input wire logic   presetn,
   tick_div_if.div    port
);
   typedef struct packed
   {
      logic [W-1:0] cnt;
      logic [W-1:0] half_q;
      logic         level;
      logic         rise;
   } div_state_t;

   div_state_t state;
   div_state_t next_state;

   // Widths under two leave no room for a count
   if (W < 2)
   begin : g_width_check
      $error("tick_divider width too small");
   end

   // New ratio taken only at the end of a high phase, so no runt pulse
   always_comb
   begin
      next_state = state;
      next_state.rise = 1'b0;
      if (port.src_tick)
      begin
         if (state.cnt + 1'b1 >= state.half_q)
         begin
            next_state.cnt = '0;
            next_state.level = ~state.level;
            next_state.rise = ~state.level;
            if (state.level)
               next_state.half_q = (port.half == '0) ? W'(1) : port.half;
         end
         else
            next_state.cnt = state.cnt + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '{cnt: '0, half_q: W'(1), level: 1'b0, rise: 1'b0};
      else
         state <= next_state;
   end

   assign port.level = state.level;
   assign port.rise  = state.rise;
endmodule
